// [design/pmx_consts.svh]
// constants of the pad multiplexer: sizes, encodings, reset values, strap timing
// assumes inclusion from the package only; holds definitions and nothing else
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH

// ----------------------------------------------------------------------------
// sizes and encodings
// ----------------------------------------------------------------------------
`define PMX_NPAD 8
`define PMX_SEL_W 4
`define PMX_NFUNC 16
`define PMX_IDX_W 3
`define PMX_SEL_GPIO 4'h0
`define PMX_VALID_MASK 16'h3fff
`define PMX_XTAL_PAD 7

// ----------------------------------------------------------------------------
// strap sampling time
// ----------------------------------------------------------------------------
`define PMX_CLK_NS 8
`define PMX_STRAP_SETTLE_NS 32
`define PMX_STRAP_SETTLE_CYC ((`PMX_STRAP_SETTLE_NS + `PMX_CLK_NS - 1) / `PMX_CLK_NS)
`define PMX_CNT_W 4

`endif

// [design/pmx_pad.sv]
// one multiplexed pad: function select, sleep override, reset release
// assumes the peripherals give a level and an enable for every encoding
`timescale 1ns/1ns
module pmx_pad import pmx_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic en,
  input wire pmx_pwr_t pwr,
  input wire logic [`PMX_SEL_W-1:0] sel,
  input wire pmx_slp_t slp,
  // peripheral side
  input wire logic [`PMX_NFUNC-1:0] fout,
  input wire logic [`PMX_NFUNC-1:0] foe,
  // pad side
  output pmx_drv_t drv
);
  pmx_pad_st_t st;
  pmx_pad_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.drv = '0;
    if (en) begin // R12
      case (pwr)
        PMX_PWR_RUN: begin
          if (pmx_sel_valid(sel)) begin // R11
            next_st.drv.o = fout[sel];
            next_st.drv.oe = foe[sel];
          end
        end
        PMX_PWR_DEEP: next_st.drv = pmx_slp_drive(slp); // R2
        PMX_PWR_HIB: next_st.drv = pmx_slp_drive(slp); // R3
        default: next_st.drv = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign drv = st.drv;
endmodule

// [design/pmx_pkg.sv]
// types shared by the pad multiplexer files
// assumes pmx_consts.svh is on the include path
package pmx_pkg;
  `include "pmx_consts.svh"

  typedef enum logic [1:0] {PMX_PWR_RUN, PMX_PWR_DEEP, PMX_PWR_HIB} pmx_pwr_t;
  typedef enum logic [2:0] {
    PMX_SLP_HIZ, PMX_SLP_PULLUP, PMX_SLP_PULLDN, PMX_SLP_DRV0, PMX_SLP_DRV1
  } pmx_slp_t;
  typedef enum logic [1:0] {PMX_BT_HOLD, PMX_BT_SETTLE, PMX_BT_RUN} pmx_boot_t;

  // one pad's drive: level, enable, weak pulls
  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
    logic pd;
  } pmx_drv_t;

  typedef struct packed {
    pmx_drv_t drv;
  } pmx_pad_st_t;

  typedef struct packed {
    pmx_boot_t boot;
    logic done;
    logic [`PMX_CNT_W-1:0] cnt;
    logic [`PMX_NPAD-1:0][`PMX_SEL_W-1:0] sel;
    logic strap2;
    logic strap_mode;
    logic slow_ext;
    logic slow_clk;
    logic [`PMX_NPAD-1:0] pad_in;
    pmx_drv_t osc_drv;
    pmx_drv_t rsw_drv;
  } pmx_top_st_t;

  localparam logic [`PMX_NFUNC-1:0] PMX_VALID = `PMX_VALID_MASK;

  function automatic logic pmx_sel_valid(input logic [`PMX_SEL_W-1:0] s);
    pmx_sel_valid = PMX_VALID[s];
  endfunction

  // sleep-state drive chosen by software, independent of the mux selection
  function automatic pmx_drv_t pmx_slp_drive(input pmx_slp_t s);
    pmx_drv_t d;
    d = '0;
    case (s)
      PMX_SLP_PULLUP: d.pu = 1'b1;
      PMX_SLP_PULLDN: d.pd = 1'b1;
      PMX_SLP_DRV0: d.oe = 1'b1;
      PMX_SLP_DRV1: begin
        d.oe = 1'b1;
        d.o = 1'b1;
      end
      default: d = '0;
    endcase
    pmx_slp_drive = d;
  endfunction
endpackage

// [design/pmx_top.sv]
// pad multiplexer with boot straps and slow-clock sensing
// assumes pad inputs already synchronous to clock and board pulls on strap pads
//
// Behaviour
// R1 - pads leave reset on GPIO, encoding zero
// R2 - deep sleep: hi-z unless software sets pull/drive
// R3 - hibernate: hi-z unless software sets pull/drive
// R4 - osc-enable strap driven high; hibernate pulled down
// R5 - software uses osc-enable pad as output only
// R6 - strap pads get output-only digital functions
// R7 - radio strap sampled at boot, then switch output
// R8 - pull-up on crystal out selects external clock
// R9 - freed crystal-out pad should carry outputs only; its selector still routes any function there, inputs too
// R10 - software pulls down flash pads in deep sleep
// R11 - selector routes one function; bad codes idle
// R12 - chip reset holds every muxed pad hi-z
`timescale 1ns/1ns
module pmx_top import pmx_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // chip state
  input wire logic chip_reset_n,
  input wire pmx_pwr_t pwr,
  // selector writes
  input wire logic cfg_we,
  input wire logic [`PMX_IDX_W-1:0] cfg_idx,
  input wire logic [`PMX_SEL_W-1:0] cfg_sel,
  // sleep-state drive per pad
  input wire pmx_slp_t [`PMX_NPAD-1:0] slp_cfg,
  input wire pmx_slp_t rsw_slp,
  // peripheral side
  input wire logic [`PMX_NPAD-1:0][`PMX_NFUNC-1:0] func_out,
  input wire logic [`PMX_NPAD-1:0][`PMX_NFUNC-1:0] func_oe,
  input wire logic band_switch,
  output logic [`PMX_NPAD-1:0] func_in,
  // multiplexed pads
  input wire logic [`PMX_NPAD-1:0] pad_i,
  output pmx_drv_t [`PMX_NPAD-1:0] pad_drv,
  // strap pads
  input wire logic osc_pad_i,
  output pmx_drv_t osc_drv,
  input wire logic rsw_pad_i,
  output pmx_drv_t rsw_drv,
  input wire logic xin_pad_i,
  // boot results
  output logic boot_done,
  output logic boot_strap_bit2,
  output logic boot_mode_strap,
  output logic slow_ext_sel,
  output logic slow_ext_clk
);
  localparam logic [`PMX_CNT_W-1:0] SETTLE_LAST = `PMX_CNT_W'(`PMX_STRAP_SETTLE_CYC - 1);

  // all state outside the pad cells lives in one struct, registered once
  pmx_top_st_t st;
  pmx_top_st_t next_st;
  logic xtal_en;

  // --------------------------------------------------------------------------
  // drive decoding
  // --------------------------------------------------------------------------
  // enable of one pad cell: chip reset releases all, crystal-out also waits for its strap
  function automatic logic pad_enable(input int idx, input logic run, input logic xtal);
    if (idx == `PMX_XTAL_PAD) begin
      pad_enable = run && xtal;
    end else begin
      pad_enable = run;
    end
  endfunction

  // osc enable: high in run and deep sleep; hibernate lets the pull-down stop the oscillator
  function automatic pmx_drv_t osc_en_drive(input pmx_pwr_t p);
    pmx_drv_t d;
    d = '0;
    case (p)
      PMX_PWR_HIB: begin
        d.pd = 1'b1; // R4
      end
      default: begin
        d.oe = 1'b1; // R4 R5 R6
        d.o = 1'b1;
      end
    endcase
    osc_en_drive = d;
  endfunction

  // radio switch: band select while running, software sleep drive otherwise
  function automatic pmx_drv_t band_sw_drive(input pmx_pwr_t p, input logic lvl,
    input pmx_slp_t s);
    pmx_drv_t d;
    d = '0;
    case (p)
      PMX_PWR_RUN: begin
        d.oe = 1'b1; // R7 R6
        d.o = lvl;
      end
      default: begin
        d = pmx_slp_drive(s); // R2 R3
      end
    endcase
    band_sw_drive = d;
  endfunction

  // last count of the strap window; strap pads stay released until it passes
  function automatic logic settle_end(input logic [`PMX_CNT_W-1:0] c);
    settle_end = (c == SETTLE_LAST);
  endfunction

  // --------------------------------------------------------------------------
  // pad cells
  // --------------------------------------------------------------------------
  // the crystal-out pad belongs to the oscillator until a pull-up was sensed
  assign xtal_en = chip_reset_n && (st.boot == PMX_BT_RUN) && st.slow_ext; // R8 R9

  genvar g;
  generate
    for (g = 0; g < `PMX_NPAD; g++) begin : g_pad
      pmx_pad u_pad (
        .clock(clock),
        .rst(rst),
        .en(pad_enable(g, chip_reset_n, xtal_en)), // R12
        .pwr(pwr),
        .sel(st.sel[g]),
        .slp(slp_cfg[g]), // R10
        .fout(func_out[g]),
        .foe(func_oe[g]),
        .drv(pad_drv[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // boot sequence, straps, selectors
  // --------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // ------------------------------------------------------------------------
    // pad sampling and slow clock
    // ------------------------------------------------------------------------
    next_st.pad_in = pad_i;
    // the slow clock is gated low until the external source has been sensed
    next_st.slow_clk = st.slow_ext & xin_pad_i; // R8

    // ------------------------------------------------------------------------
    // selector writes
    // ------------------------------------------------------------------------
    if (cfg_we) begin
      next_st.sel[cfg_idx] = cfg_sel; // R11
    end

    // ------------------------------------------------------------------------
    // boot sequence
    // ------------------------------------------------------------------------
    case (st.boot)
      PMX_BT_HOLD: begin
        // strap pads released so the board pulls can be read
        next_st.cnt = '0;
        next_st.osc_drv = '0;
        next_st.rsw_drv = '0;
        if (chip_reset_n) begin
          next_st.boot = PMX_BT_SETTLE;
        end
      end
      PMX_BT_SETTLE: begin
        // straps float on board pulls while the pads stay released
        next_st.cnt = st.cnt + `PMX_CNT_W'(1);
        if (settle_end(st.cnt)) begin
          next_st.strap2 = osc_pad_i;
          next_st.strap_mode = rsw_pad_i; // R7
          next_st.slow_ext = pad_i[`PMX_XTAL_PAD]; // R8
          next_st.boot = PMX_BT_RUN;
        end
      end
      PMX_BT_RUN: begin
        // osc enable stays an output once running, except hibernate releases it to the pull-down
        next_st.osc_drv = osc_en_drive(pwr); // R4 R5 R6
        next_st.rsw_drv = band_sw_drive(pwr, band_switch, rsw_slp); // R7
      end
      default: next_st.boot = PMX_BT_HOLD;
    endcase

    // ------------------------------------------------------------------------
    // chip reset override
    // ------------------------------------------------------------------------
    // chip reset wins over a selector write or boot step in the same cycle
    if (!chip_reset_n) begin
      next_st.boot = PMX_BT_HOLD;
      next_st.cnt = '0;
      next_st.osc_drv = '0; // R12
      next_st.rsw_drv = '0;
      next_st.slow_ext = 1'b0;
      for (int i = 0; i < `PMX_NPAD; i++) begin
        next_st.sel[i] = `PMX_SEL_GPIO; // R1
      end
    end

    // boot_done comes from its own flip-flop rather than a state decode
    next_st.done = (next_st.boot == PMX_BT_RUN);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0; // R1
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  // every output is a state register or a pad cell register
  assign func_in = st.pad_in;
  assign osc_drv = st.osc_drv;
  assign rsw_drv = st.rsw_drv;
  assign boot_done = st.done;
  assign boot_strap_bit2 = st.strap2;
  assign boot_mode_strap = st.strap_mode;
  assign slow_ext_sel = st.slow_ext;
  assign slow_ext_clk = st.slow_clk;
endmodule

// [sim/pad_mux_low_power_states_test.sv]
// bench for the pad multiplexer: selection table, straps, sleep, chip reset
// assumes pmx_board models the strap pulls and the slow clock source
`timescale 1ns/1ns
module pad_mux_low_power_states_test import pmx_pkg::*;;
  typedef struct packed {logic [2:0] i; logic [3:0] s; pmx_pwr_t p; pmx_slp_t l;} pmx_row_t;
  localparam logic [15:0] FO = 16'h5a3d;
  localparam logic [15:0] FOE = 16'haff1;
  localparam logic [4:0][3:0] SLP = {4'hc, 4'h4, 4'h1, 4'h2, 4'h0};
  // rows: pad, encoding, power state, sleep drive; 14 and 15 must stay idle
  localparam pmx_row_t ROWS [8] = '{
    '{3'h2, 4'h3, PMX_PWR_RUN, PMX_SLP_HIZ}, '{3'h3, 4'hd, PMX_PWR_RUN, PMX_SLP_HIZ},
    '{3'h4, 4'he, PMX_PWR_RUN, PMX_SLP_HIZ}, '{3'h5, 4'hf, PMX_PWR_RUN, PMX_SLP_HIZ},
    '{3'h1, 4'h5, PMX_PWR_DEEP, PMX_SLP_PULLUP}, '{3'h6, 4'h9, PMX_PWR_DEEP, PMX_SLP_DRV1},
    '{3'h2, 4'h3, PMX_PWR_HIB, PMX_SLP_PULLDN}, '{3'h3, 4'h7, PMX_PWR_HIB, PMX_SLP_DRV0}};
  logic clock = 1'b0, rst = 1'b1, chip_reset_n = 1'b0, cfg_we = 1'b0, band_switch = 1'b0;
  pmx_pwr_t pwr = PMX_PWR_RUN;
  logic [2:0] cfg_idx = 3'h0;
  logic [3:0] cfg_sel = 4'h0;
  pmx_slp_t [7:0] slp_cfg = '{default: PMX_SLP_HIZ};
  pmx_slp_t rsw_slp = PMX_SLP_PULLDN;
  logic [7:0][15:0] func_out = {8{FO}}, func_oe = {8{FOE}};
  logic [7:0] func_in, pad_i;
  pmx_drv_t [7:0] pad_drv;
  pmx_drv_t osc_drv, rsw_drv;
  logic osc_pad_i, rsw_pad_i, xin_pad_i, boot_done, boot_strap_bit2, boot_mode_strap;
  logic slow_ext_sel, slow_ext_clk, pad7;
  int fail_count = 0, comparisons = 0, hi_cnt = 0;
  assign pad_i = {pad7, 7'h2a};
  always #4 clock = ~clock;
  pmx_top i_dut (.*);
  pmx_board #(.STRAP2(1'b1), .MODE(1'b0)) i_brd (.clock, .osc_drv, .rsw_drv,
    .x_drv(pad_drv[7]), .osc_pad_i, .rsw_pad_i, .x_pad_i(pad7), .xin_pad_i);
  function automatic logic [3:0] expd(input pmx_row_t r);
    if (r.p != PMX_PWR_RUN) return SLP[r.l];
    return PMX_VALID[r.s] ? {FO[r.s], FOE[r.s], 2'h0} : 4'h0;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic write_sel(input logic [2:0] i, input logic [3:0] s);
    cfg_idx = i;
    cfg_sel = s;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    tick(2);
  endtask
  task automatic boot();
    chip_reset_n = 1'b1;
    for (int k = 0; k < 20 && boot_done !== 1'b1; k++) tick(1);
    if (boot_done !== 1'b1) begin
      fail_count++;
      give_verdict();
    end else begin
      tick(1);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    tick(6);
    rst = 1'b0;
    tick(2);
    chk("pad_drv in reset", pad_drv, '0);
    boot();
    chk("boot_strap_bit2", boot_strap_bit2, 1'b1);
    chk("boot_mode_strap", boot_mode_strap, 1'b0);
    chk("slow_ext_sel", slow_ext_sel, 1'b1);
    chk("osc_drv running", osc_drv, 4'hc);
    chk("default function", pad_drv[5], 4'hc);
    for (int k = 0; k < 12; k++) begin
      hi_cnt += slow_ext_clk;
      tick(1);
    end
    chk("slow_ext_clk high cycles", hi_cnt, 6);
    for (int r = 0; r < 8; r++) begin
      pwr = ROWS[r].p;
      slp_cfg = '{default: ROWS[r].l};
      write_sel(ROWS[r].i, ROWS[r].s);
      chk("row pad_drv", pad_drv[ROWS[r].i], expd(ROWS[r]));
    end
    chk("osc_drv hibernate", osc_drv, 4'h1);
    chk("rsw_drv hibernate", rsw_drv, 4'h1);
    pwr = PMX_PWR_DEEP;
    slp_cfg = '{default: PMX_SLP_PULLDN};
    tick(2);
    chk("flash pads pulled down", pad_drv, {8{4'h1}});
    chk("osc_drv deep sleep", osc_drv, 4'hc);
    pwr = PMX_PWR_RUN;
    band_switch = 1'b1;
    tick(2);
    chk("rsw_drv", rsw_drv, 4'hc);
    write_sel(3'h7, 4'h2);
    chk("freed crystal pad", pad_drv[7], {FO[2], FOE[2], 2'h0});
    chk("func_in released", func_in, 8'haa);
    write_sel(3'h7, 4'h6);
    chk("crystal pad driven", pad_drv[7], {FO[6], FOE[6], 2'h0});
    chk("func_in driven", func_in, 8'h2a);
    chip_reset_n = 1'b0;
    tick(3);
    chk("pad_drv in chip reset", pad_drv, '0);
    chk("slow_ext cleared", {slow_ext_sel, slow_ext_clk}, 2'h0);
    write_sel(3'h2, 4'h3);
    boot();
    chk("function after chip reset", pad_drv[2], 4'hc);
    give_verdict();
  end
endmodule

// [sim/pmx_board.sv]
// board model: strap resistors, crystal-out pull-up and a free-running slow clock
// assumes pad drive structs come straight from pmx_top
`timescale 1ns/1ns
module pmx_board import pmx_pkg::*; #(
  parameter logic STRAP2 = 1'b1,
  parameter logic MODE = 1'b0,
  parameter int HALF = 6
) (
  // clock
  input wire logic clock,
  // pad drives from the device
  input wire pmx_drv_t osc_drv,
  input wire pmx_drv_t rsw_drv,
  input wire pmx_drv_t x_drv,
  // resolved pad levels
  output logic osc_pad_i,
  output logic rsw_pad_i,
  output logic x_pad_i,
  output logic xin_pad_i
);
  int cnt = 0;
  // the board never drives a strap pad; undriven pads fall to the board resistor, but the osc pad reads low while its pull-down is on
  assign osc_pad_i = osc_drv.oe ? osc_drv.o : STRAP2 & !osc_drv.pd;
  assign rsw_pad_i = rsw_drv.oe ? rsw_drv.o : MODE;
  assign x_pad_i = x_drv.oe ? x_drv.o : 1'b1;
  // square wave runs free; far faster than the real one to keep the run short
  logic xin = 1'b0;
  assign xin_pad_i = xin;
  always @(posedge clock) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) xin <= ~xin;
  end
endmodule

// [sim/pmx_top_props.sv]
// checker on the pmx_top ports: routing, sleep drive, straps, chip reset
// assumes binding onto pmx_top; board pulls hold strap pads steady
`timescale 1ns/1ns
module pmx_top_props import pmx_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic chip_reset_n,
  input wire pmx_pwr_t pwr,
  input wire logic cfg_we,
  input wire logic [2:0] cfg_idx,
  input wire logic [3:0] cfg_sel,
  input wire pmx_slp_t [7:0] slp_cfg,
  input wire logic band_switch,
  input wire logic [7:0][15:0] func_out,
  input wire logic [7:0][15:0] func_oe,
  // pads and boot results
  input wire pmx_drv_t [7:0] pad_drv,
  input wire pmx_drv_t osc_drv,
  input wire pmx_drv_t rsw_drv,
  input wire logic osc_pad_i,
  input wire logic boot_done,
  input wire logic boot_strap_bit2
);
  localparam logic [4:0][3:0] SLP = {4'hc, 4'h4, 4'h1, 4'h2, 4'h0};
  logic [7:0][3:0] sel_m;
  pmx_drv_t [7:0] exp_d;
  logic run_ok;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  assign run_ok = boot_done && chip_reset_n;
  // mirror of the selectors; chip reset clears them like rst
  always_ff @(posedge clock or posedge rst)
    if (rst) sel_m <= '0;
    else if (!chip_reset_n) sel_m <= '0;
    else if (cfg_we) sel_m[cfg_idx] <= cfg_sel;
  always_comb
    for (int i = 0; i < 8; i++)
      exp_d[i] = pwr != PMX_PWR_RUN ? SLP[slp_cfg[i]] :
        PMX_VALID[sel_m[i]] ? {func_out[i][sel_m[i]], func_oe[i][sel_m[i]], 2'h0} : '0;
  a_reset_hiz: assert property (!chip_reset_n [*2] |=> pad_drv == '0)
    else $error("pads driven in chip reset");
  a_boot_delay: assert property ($rose(chip_reset_n) |-> !boot_done [*5] ##1 boot_done)
    else $error("strap sampling at wrong edge");
  a_strap_bit2: assert property ($rose(boot_done) |-> boot_strap_bit2 == $past(osc_pad_i))
    else $error("strap bit two missampled");
  a_osc_high: assert property (run_ok && pwr != PMX_PWR_HIB |=> osc_drv == 4'hc)
    else $error("osc enable not driven high");
  a_osc_hib: assert property (run_ok && pwr == PMX_PWR_HIB |=> osc_drv == 4'h1)
    else $error("osc enable not pulled down");
  a_switch_drive: assert property (run_ok && pwr == PMX_PWR_RUN
    |=> rsw_drv == {$past(band_switch), 3'h4}) else $error("radio switch not driven");
  for (genvar i = 0; i < 7; i++) begin : g_pad
    a_pad_route: assert property (run_ok && pwr == PMX_PWR_RUN
      |=> pad_drv[i] == $past(exp_d[i])) else $error("pad routing wrong");
    a_pad_sleep: assert property (run_ok && pwr != PMX_PWR_RUN
      |=> pad_drv[i] == $past(exp_d[i])) else $error("pad sleep drive wrong");
  end
  c_boot: cover property ($rose(boot_done));
  c_hib: cover property (run_ok && pwr == PMX_PWR_HIB);
  c_refused: cover property (cfg_we && !PMX_VALID[cfg_sel]);
endmodule
bind pmx_top pmx_top_props u_props (.*);
